/* rtl/ras_pkg.sv */
// constants, register map and field layout of the alarm and status block
package ras_pkg;
   localparam int unsigned ADDR_W = 8;
   // printed offsets are word multiples, so they are byte addresses
   localparam logic [7:0] OFF_TIME_ALARM      = 8'h10;
   localparam logic [7:0] OFF_CALENDAR_ALARM  = 8'h14;
   localparam logic [7:0] OFF_EVENT_STATUS    = 8'h18;
   localparam logic [7:0] OFF_STATUS_CLEAR    = 8'h1C;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET  = 8'h20;
   localparam logic [7:0] OFF_IRQ_DISABLE     = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK        = 8'h28;
   localparam logic [7:0] OFF_CONTROL         = 8'h00;
   localparam logic [31:0] RST_TIME_ALARM     = 32'h0000_0000;
   localparam logic [31:0] RST_CALENDAR_ALARM = 32'h0101_0000;
   // time alarm fields
   localparam int unsigned SEC_LSB = 0;
   localparam int unsigned SEC_EN  = 7;
   localparam int unsigned MIN_LSB = 8;
   localparam int unsigned MIN_EN  = 15;
   localparam int unsigned HOUR_LSB = 16;
   localparam int unsigned PM_BIT  = 22;
   localparam int unsigned HOUR_EN = 23;
   // calendar alarm fields
   localparam int unsigned MONTH_LSB = 16;
   localparam int unsigned MONTH_EN  = 23;
   localparam int unsigned DATE_LSB  = 24;
   localparam int unsigned DATE_EN   = 31;
   // status flag positions
   localparam int unsigned FLG_ACK = 0;
   localparam int unsigned FLG_ALR = 1;
   localparam int unsigned FLG_SEC = 2;
   localparam int unsigned FLG_TIM = 3;
   localparam int unsigned FLG_CAL = 4;
   localparam int unsigned NFLAGS  = 5;
   // control register fields
   localparam int unsigned CTL_UPDTIME = 0;
   localparam int unsigned CTL_CAL_UPDATE = 1;
   localparam int unsigned CTL_TSEL    = 8;
   localparam int unsigned CTL_CSEL    = 16;
   localparam logic [1:0] TSEL_MINUTE   = 2'h0;
   localparam logic [1:0] TSEL_HOUR     = 2'h1;
   localparam logic [1:0] TSEL_MIDNIGHT = 2'h2;
   localparam logic [1:0] TSEL_NOON     = 2'h3;
   localparam logic [1:0] CSEL_WEEK  = 2'h0;
   localparam logic [1:0] CSEL_MONTH = 2'h1;
   localparam logic [1:0] CSEL_YEAR  = 2'h2;
   typedef enum logic [1:0] {RAS_FREE, RAS_WAIT, RAS_GRANTED} ras_upd_t;
endpackage

/* rtl/ras_flag_if.sv */
// flag set and clear bundle between the top and the flag keeper
`timescale 1ns/1ns
interface ras_flag_if;
   logic [4:0] set;
   logic [4:0] clr;
   logic [4:0] flags;
   modport keeper (input set, input clr, output flags);
   modport user   (output set, output clr, input flags);
endinterface

/* rtl/ras_alarm_cmp.sv */
// alarm comparator for time and calendar alarm registers
`timescale 1ns/1ns
module ras_alarm_cmp (
   input  wire logic [31:0] time_alarm,
   input  wire logic [31:0] calendar_alarm,
   input  wire logic [6:0]  cur_second,
   input  wire logic [6:0]  cur_minute,
   input  wire logic [5:0]  cur_hour,
   input  wire logic        cur_pm,
   input  wire logic [5:0]  cur_date,
   input  wire logic [4:0]  cur_month,
   output logic             match
);
   logic s_en, m_en, h_en, d_en, mo_en;
   logic s_ok, m_ok, h_ok, d_ok, mo_ok;
   always_comb begin
      s_en  = time_alarm[ras_pkg::SEC_EN];
      m_en  = time_alarm[ras_pkg::MIN_EN];
      h_en  = time_alarm[ras_pkg::HOUR_EN];
      d_en  = calendar_alarm[ras_pkg::DATE_EN];
      mo_en = calendar_alarm[ras_pkg::MONTH_EN];
      s_ok  = time_alarm[ras_pkg::SEC_LSB +: 7] == cur_second; // R1
      m_ok  = time_alarm[ras_pkg::MIN_LSB +: 7] == cur_minute; // R3
      h_ok  = {time_alarm[ras_pkg::PM_BIT], time_alarm[ras_pkg::HOUR_LSB +: 6]}
              == {cur_pm, cur_hour}; // R5
      d_ok  = calendar_alarm[ras_pkg::DATE_LSB +: 6] == cur_date; // R7
      mo_ok = calendar_alarm[ras_pkg::MONTH_LSB +: 5] == cur_month; // R8
      // disabled fields pass; nothing enabled never matches
      match = (s_en | m_en | h_en | d_en | mo_en)
              & (~s_en | s_ok) & (~m_en | m_ok) & (~h_en | h_ok) // R2 R4
              & (~d_en | d_ok) & (~mo_en | mo_ok); // R23
   end
endmodule

/* rtl/ras_flags.sv */
// sticky status flags; a set in the clear cycle wins
`timescale 1ns/1ns
module ras_flags (
   input  wire logic clk,
   input  wire logic rst,
   ras_flag_if.keeper f
);
   logic [4:0] flags_reg;
   always_ff @(posedge clk) begin
      if (rst) begin
         flags_reg <= 5'h00;
      end else begin
         flags_reg <= (flags_reg & ~f.clr) | f.set; // R11 R12 R15
      end
   end
   assign f.flags = flags_reg;
endmodule

/* rtl/ras_top.sv */
// alarm compare, sticky status, clear and interrupt enable logic of the clock
//
// Notes on behaviour
// R1: second alarm compared when bit 7 set
// R2: bit 15 enables minute alarm matching
// R3: minute alarm compared with BCD minute
// R4: bit 23 enables hour and PM matching
// R5: hour alarm plus PM compared with hour
// R6: software disables, rewrites, re-enables time fields
// R7: bit 31 enables date alarm matching
// R8: calendar bit 23 enables month matching
// R9: software disables, rewrites, re-enables date/month
// R10: status bit 0 shows update granted
// R11: status bit 1 sticky alarm flag
// R12: status bit 2 sticky second flag
// R13: status bit 3 sticky selected time event
// R14: status bit 4 sticky selected calendar event
// R15: clear register ones clear flags 0-4
// R16: enable bit 0 enables update interrupt
// R17: enable bit 1 enables alarm interrupt
// R18: enable bit 2 enables second interrupt
// R19: enable bits 3,4 enable time/calendar
// R20: calendar select 0 week,1 month,2 year
// R21: disable register ones disable interrupts
// R22: grant only after time update request
// R23: all enabled fields equal; none never matches
// R24: irq when any enabled flag set
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module ras_top (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata,
   input  wire logic [6:0]  cur_second,
   input  wire logic [6:0]  cur_minute,
   input  wire logic [5:0]  cur_hour,
   input  wire logic        cur_pm,
   input  wire logic [5:0]  cur_date,
   input  wire logic [4:0]  cur_month,
   input  wire logic        second_tick,
   input  wire logic        minute_change,
   input  wire logic        hour_change,
   input  wire logic        midnight,
   input  wire logic        noon,
   input  wire logic        week_change,
   input  wire logic        month_change,
   input  wire logic        year_change,
   input  wire logic        counters_stopped,
   output logic             time_update_request,
   output logic [1:0]       time_event_select,
   output logic [1:0]       calendar_event_select,
   output logic             irq
);
   logic [31:0]        time_alarm_reg;
   logic [31:0]        calendar_alarm_reg;
   logic [31:0]        control_reg;
   logic [4:0]         irq_mask_reg;
   logic               match;
   logic               match_q_reg;
   logic               time_ev;
   logic               cal_ev;
   logic               update_granted_flag;
   logic [31:0]        rdata_reg;
   ras_pkg::ras_upd_t  upd_reg;
   ras_pkg::ras_upd_t  upd_next;
   ras_flag_if         fl ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   ras_alarm_cmp u_cmp (
      .time_alarm     (time_alarm_reg),
      .calendar_alarm (calendar_alarm_reg),
      .cur_second     (cur_second),
      .cur_minute     (cur_minute),
      .cur_hour       (cur_hour),
      .cur_pm         (cur_pm),
      .cur_date       (cur_date),
      .cur_month      (cur_month),
      .match          (match)
   );

   ras_flags u_flags (
      .clk (clk),
      .rst (rst),
      .f   (fl.keeper)
   );

   // alarm registers; software follows disable, write, enable sequence
   always_ff @(posedge clk) begin
      if (rst) begin
         time_alarm_reg     <= ras_pkg::RST_TIME_ALARM;
         calendar_alarm_reg <= ras_pkg::RST_CALENDAR_ALARM;
      end else if (wr) begin
         if (hit(addr, ras_pkg::OFF_TIME_ALARM)) begin
            time_alarm_reg <= wdata & 32'h00FF_FF7F | (wdata & 32'h0000_0080); // R6
         end
         if (hit(addr, ras_pkg::OFF_CALENDAR_ALARM)) begin
            calendar_alarm_reg <= wdata & 32'hBF9F_0000; // R9
         end
      end
   end

   // control: update request and event selections
   always_ff @(posedge clk) begin
      if (rst) begin
         control_reg <= 32'h0000_0000;
      end else if (wr && hit(addr, ras_pkg::OFF_CONTROL)) begin
         control_reg <= wdata & 32'h0003_0303;
      end
   end

   assign time_update_request   = control_reg[ras_pkg::CTL_UPDTIME];
   assign time_event_select     = control_reg[ras_pkg::CTL_TSEL +: 2];
   assign calendar_event_select = control_reg[ras_pkg::CTL_CSEL +: 2];

   // grant after request and counters stopped; a new grant needs a new request
   always_comb begin
      upd_next = upd_reg;
      case (upd_reg)
         ras_pkg::RAS_FREE: begin
            if (time_update_request) begin
               upd_next = ras_pkg::RAS_WAIT; // R22
            end
         end
         ras_pkg::RAS_WAIT: begin
            if (!time_update_request) begin
               upd_next = ras_pkg::RAS_FREE;
            end else if (counters_stopped) begin
               upd_next = ras_pkg::RAS_GRANTED; // R22
            end
         end
         ras_pkg::RAS_GRANTED: begin
            if (!time_update_request) begin
               upd_next = ras_pkg::RAS_FREE;
            end
         end
         default: upd_next = ras_pkg::RAS_FREE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         upd_reg <= ras_pkg::RAS_FREE;
      end else begin
         upd_reg <= upd_next;
      end
   end

   // one-cycle pulse on entry to granted state
   assign update_granted_flag = (upd_next == ras_pkg::RAS_GRANTED)
                                && (upd_reg != ras_pkg::RAS_GRANTED); // R10

   // edge on the match so a held match sets the flag once
   always_ff @(posedge clk) begin
      if (rst) begin
         match_q_reg <= 1'b0;
      end else begin
         match_q_reg <= match;
      end
   end

   always_comb begin
      case (time_event_select)
         ras_pkg::TSEL_MINUTE:   time_ev = minute_change;
         ras_pkg::TSEL_HOUR:     time_ev = hour_change;
         ras_pkg::TSEL_MIDNIGHT: time_ev = midnight;
         ras_pkg::TSEL_NOON:     time_ev = noon;
         default:                time_ev = 1'b0;
      endcase
   end

   // select value 3 is undefined and raises nothing
   always_comb begin
      case (calendar_event_select)
         ras_pkg::CSEL_WEEK:  cal_ev = week_change; // R20
         ras_pkg::CSEL_MONTH: cal_ev = month_change; // R20
         ras_pkg::CSEL_YEAR:  cal_ev = year_change; // R20
         default:             cal_ev = 1'b0;
      endcase
   end

   always_comb begin
      fl.set = 5'h00;
      fl.set[ras_pkg::FLG_ACK] = update_granted_flag; // R10
      fl.set[ras_pkg::FLG_ALR] = match & ~match_q_reg; // R11
      fl.set[ras_pkg::FLG_SEC] = second_tick; // R12
      fl.set[ras_pkg::FLG_TIM] = time_ev; // R13
      fl.set[ras_pkg::FLG_CAL] = cal_ev; // R14
      fl.clr = 5'h00;
      if (wr && hit(addr, ras_pkg::OFF_STATUS_CLEAR)) begin
         fl.clr = wdata[ras_pkg::NFLAGS-1:0]; // R15
      end
   end

   // interrupt mask: set by enable writes, cleared by disable writes
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask_reg <= 5'h00;
      end else if (wr && hit(addr, ras_pkg::OFF_IRQ_ENABLE_SET)) begin
         irq_mask_reg <= irq_mask_reg | wdata[ras_pkg::NFLAGS-1:0]; // R16 R17 R18 R19
      end else if (wr && hit(addr, ras_pkg::OFF_IRQ_DISABLE)) begin
         irq_mask_reg <= irq_mask_reg & ~wdata[ras_pkg::NFLAGS-1:0]; // R21
      end
   end

   assign irq = |(fl.flags & irq_mask_reg); // R24

   // read data valid in the cycle after rd; unmapped and write-only read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd) begin
         case (addr)
            ras_pkg::OFF_CONTROL:        rdata_reg <= control_reg;
            ras_pkg::OFF_TIME_ALARM:     rdata_reg <= time_alarm_reg;
            ras_pkg::OFF_CALENDAR_ALARM: rdata_reg <= calendar_alarm_reg;
            ras_pkg::OFF_EVENT_STATUS:   rdata_reg <= {27'h0, fl.flags};
            ras_pkg::OFF_IRQ_MASK:       rdata_reg <= {27'h0, irq_mask_reg};
            default:                     rdata_reg <= 32'h0000_0000;
         endcase
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign rdata = rdata_reg;
endmodule

/* tb/ras_top_properties.sv */
// checker of bus, flag and interrupt behaviour at the top ports
`timescale 1ns/1ns
module ras_top_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        second_tick,
   input wire logic        week_change,
   input wire logic        time_update_request,
   input wire logic [1:0]  time_event_select,
   input wire logic [1:0]  calendar_event_select,
   input wire logic        irq
);
   logic [4:0] mask_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // shadow mask from bus writes; the mask is only reachable that way
   always_ff @(posedge clk) begin
      if (rst)
         mask_reg <= 5'h00;
      else if (wr && addr == 8'h20)
         mask_reg <= mask_reg | wdata[4:0];
      else if (wr && addr == 8'h24)
         mask_reg <= mask_reg & ~wdata[4:0];
   end
   a_wo_reads_zero: assert property (rd && (addr == 8'h1C || addr == 8'h20
      || addr == 8'h24) |=> rdata == 32'h0)
      else $error("write-only read not zero");
   a_status_upper_zero: assert property (rd && addr == 8'h18 |=> rdata[31:5] == 27'h0)
      else $error("status upper bits set");
   a_mask_readback: assert property (rd && addr == 8'h28
      |=> rdata == {27'h0, $past(mask_reg)})
      else $error("mask readback wrong");
   a_irq_needs_mask: assert property (irq |-> mask_reg != 5'h00)
      else $error("irq without enable");
   a_second_irq: assert property (second_tick && mask_reg[2] && !wr |=> irq)
      else $error("second event gave no irq");
   a_week_irq: assert property (week_change && calendar_event_select == 2'h0
      && mask_reg[4] && !wr |=> irq)
      else $error("week event gave no irq");
   a_irq_sticky_hold: assert property (irq && !wr |=> irq)
      else $error("irq dropped without write");
   a_ctrl_out_follow: assert property (wr && addr == 8'h00 |=>
      time_update_request == $past(wdata[0]) && time_event_select == $past(wdata[9:8])
      && calendar_event_select == $past(wdata[17:16]))
      else $error("control outputs wrong");
   c_second_irq: cover property (second_tick && mask_reg[2]);
   c_week_irq: cover property (week_change && mask_reg[4]);
   c_mask_read: cover property (rd && addr == 8'h28);
endmodule
bind ras_top ras_top_properties u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .second_tick(second_tick), .week_change(week_change),
   .time_update_request(time_update_request), .time_event_select(time_event_select),
   .calendar_event_select(calendar_event_select), .irq(irq));

/* tb/tb_ras_top.sv */
// self-checking bench for the alarm, status and interrupt enable block
`timescale 1ns/1ns
module tb_ras_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] tnow = 32'h0051_3045;
   logic [31:0] cnow = 32'h1508_0000;
   logic [7:0]  ev = 8'h00;
   logic        stopped = 1'b0;
   logic        upd_req;
   logic        irq;
   logic [31:0] d;
   int          n_fail = 0;
   int          samples_checked = 0;
   always #10 clk = ~clk;
   ras_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .cur_second(tnow[6:0]), .cur_minute(tnow[14:8]), .cur_hour(tnow[21:16]),
      .cur_pm(tnow[22]), .cur_date(cnow[29:24]), .cur_month(cnow[20:16]), .second_tick(ev[0]),
      .minute_change(ev[1]), .hour_change(ev[2]), .midnight(ev[3]), .noon(ev[4]),
      .week_change(ev[5]), .month_change(ev[6]), .year_change(ev[7]),
      .counters_stopped(stopped), .time_update_request(upd_req), .time_event_select(),
      .calendar_event_select(), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      ev <= 8'h01 << i;
      @(posedge clk);
      ev <= 8'h00;
   endtask
   task automatic t_alarm();
      logic [7:0]  ta [5] = '{8'h10, 8'h10, 8'h10, 8'h14, 8'h14};
      logic [31:0] tg [5] = '{32'hC5, 32'hB000, 32'hD1_0000, 32'h9500_0000, 32'h88_0000};
      logic [31:0] tx [5] = '{32'h1, 32'h100, 32'h40_0000, 32'h100_0000, 32'h1_0000};
      rreg(8'h14);
      chk(d, 32'h0101_0000);
      for (int i = 0; i < 5; i++) begin
         wreg(ta[i], tg[i] & 32'h7F7F_7F7F);
         rreg(8'h18);
         chk(d, 32'h0);
         wreg(ta[i], tg[i] ^ tx[i]);
         rreg(8'h18);
         chk(d, 32'h0);
         wreg(ta[i], tg[i]);
         rreg(ta[i]);
         chk(d, tg[i]);
         wreg(ta[i], 32'h0);
         rreg(8'h18);
         chk(d, 32'h2);
         wreg(8'h1C, 32'h2);
         rreg(8'h18);
         chk(d, 32'h0);
      end
      $display("alarm test done");
   endtask
   task automatic t_events();
      for (int s = 0; s < 4; s++) begin
         wreg(8'h00, 32'(s) << 8);
         pulse(1 + (s + 1) % 4);
         rreg(8'h18);
         chk(d, 32'h0);
         pulse(1 + s);
         wreg(8'h1C, 32'h17);
         rreg(8'h18);
         chk(d, 32'h8);
         wreg(8'h1C, 32'h8);
      end
      for (int c = 0; c < 3; c++) begin
         wreg(8'h00, 32'(c) << 16);
         pulse(5 + (c + 1) % 3);
         rreg(8'h18);
         chk(d, 32'h0);
         pulse(5 + c);
         pulse(0);
         pulse(0);
         rreg(8'h18);
         chk(d, 32'h14);
         wreg(8'h1C, 32'h14);
      end
      rreg(8'h18);
      chk(d, 32'h0);
      $display("event test done");
   endtask
   task automatic t_irq();
      wreg(8'h00, 32'h0);
      for (int b = 0; b < 5; b++) begin
         wreg(8'h20, 32'h1 << b);
         rreg(8'h28);
         chk(d, (32'h2 << b) - 32'h1);
      end
      wreg(8'h24, 32'h1B);
      wreg(8'h20, 32'h0);
      pulse(0);
      #1 chk(32'(irq), 32'h1);
      wreg(8'h24, 32'h4);
      #1 chk(32'(irq), 32'h0);
      wreg(8'h20, 32'h10);
      pulse(5);
      #1 chk(32'(irq), 32'h1);
      wreg(8'h1C, 32'h1F);
      #1 chk(32'(irq), 32'h0);
      wreg(8'h24, 32'h1F);
      $display("irq test done");
   endtask
   task automatic t_update();
      @(posedge clk);
      stopped <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(8'h18);
      chk(d, 32'h0);
      @(posedge clk);
      stopped <= 1'b0;
      wreg(8'h00, 32'h1);
      #1 chk(32'(upd_req), 32'h1);
      repeat (3) @(posedge clk);
      rreg(8'h18);
      chk(d, 32'h0);
      @(posedge clk);
      stopped <= 1'b1;
      for (int k = 0; k < 8 && d[0] !== 1'b1; k++)
         rreg(8'h18);
      chk(d, 32'h1);
      wreg(8'h00, 32'h0);
      stopped <= 1'b0;
      wreg(8'h1C, 32'h1);
      rreg(8'h18);
      chk(d, 32'h0);
      rreg(8'h2C);
      chk(d, 32'h0);
      rreg(8'h1C);
      chk(d, 32'h0);
      rreg(8'h20);
      chk(d, 32'h0);
      rreg(8'h24);
      chk(d, 32'h0);
      $display("update test done");
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_alarm();
      t_events();
      t_irq();
      t_update();
      results();
   end
   // tests need about three hundred cycles
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule
